// ==== design/vcp_map.vh ====
`ifndef VCP_MAP_VH
`define VCP_MAP_VH
`define VCP_A_LCMP 24'h09_0020
`define VCP_A_CTRL 24'h09_8000
`define VCP_A_CROP 24'h09_8004
`define VCP_A_DIM 24'h09_8008
`define VCP_A_BUF0 24'h09_800C
`define VCP_A_BUF1 24'h09_8010
`define VCP_A_PITCH 24'h09_8014
`define VCP_A_FIFO 24'h09_8018
`define VCP_A_CONST 24'h09_801C
`define VCP_RST_FIFO 3'h4
`define VCP_RST_CONST 32'h00ED_EDED
`define VCP_CTRL_WMASK 32'h001F_FFFF
`define VCP_BUF_WMASK 32'h8FFF_FFF0
`define VCP_PITCH_WMASK 32'h0000_FFF0
`define VCP_CROP_WMASK 32'h03FF_03FF
`define VCP_DIM_WMASK 32'h07FF_07FF
`define VCP_LCMP_WMASK 32'h0000_07FF
`define B_EN 0
`define B_656 1
`define B_RGB 2
`define B_CC 3
`define B_DB 4
`define B_BOB 5
`define B_WEAVE 6
`define B_FSW 7
`define B_FMT 8
`define B_W8 9
`define B_BSW 10
`define B_UVS 11
`define B_CKP 12
`define B_LRP 13
`define B_VSP 14
`define B_FD 15
`define B_HS 16
`define B_VS 17
`define B_HA 18
`define B_ADJ 19
`define B_PNL 20
`define B_VSS 24
`define B_CB 25
`define B_IL 26
`define B_FLD 27
`define B_FLIP 31
`define EAV_XY_V 5
`define EAV_XY_H 4
`define EAV_XY_F 6
`define SAV_FF 8'hFF
`define FIFO_DEPTH 5'h10
`endif

// ==== design/vcp_linebuf.v ====
`timescale 1ns/1ps
// Small pixel staging memory; read data registered
module vcp_linebuf (
    // Clock
    input wire clk,
    // Write side
    input wire we,
    input wire [3:0] waddr,
    input wire [15:0] wdata,
    // Read side
    input wire [3:0] raddr,
    output reg [15:0] rdata
);
    reg [15:0] mem [0:15];
    // Synchronous write and registered read
    always @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule

// ==== design/vcp_capture.v ====
// Strobed register access was decided locally.
`timescale 1ns/1ps
`include "vcp_map.vh"
module vcp_capture (
    // System
    input wire CLK_SYS,
    input wire RSTN,
    // Register port
    input wire [23:0] ADDR,
    input wire [31:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [31:0] RDATA,
    // Video pins
    input wire PCLK,
    input wire VSYNC,
    input wire LINE_REF,
    input wire [15:0] VDATA,
    // Memory side
    input wire MEM_RD_REQ,
    output wire FIFO_REQ,
    output reg [15:0] MEM_DATA,
    output reg [25:0] MEM_ADDR,
    output reg MEM_EXT,
    output reg MEM_CS,
    // Panel
    output reg PANEL_VALID,
    output reg [15:0] PANEL_DATA,
    output reg PANEL_TRIG
);
    reg [31:0] ctrl_r, crop_r, dim_r, buf0_r, buf1_r, pitch_r, const_r, lcmp_r;
    reg [2:0] fifo_r;
    // Synchronisers: first stage read only by the second
    reg [18:0] s1_r, s2_r;
    reg ck_d_r, vs_d_r, lr_d_r, lr_adj_r;
    always @(posedge CLK_SYS) begin
        s1_r <= {PCLK, VSYNC, LINE_REF, VDATA};
        s2_r <= s1_r;
    end
    // Polarity-corrected levels
    wire ck = s2_r[18] ^ ctrl_r[`B_CKP];
    wire vs_raw = s2_r[17] ^ ctrl_r[`B_VSP];
    wire lr_raw = s2_r[16] ^ ctrl_r[`B_LRP];
    wire [15:0] din = s2_r[15:0];
    wire pix_en = ck & ~ck_d_r;
    wire lr_use = ctrl_r[`B_ADJ] ? lr_adj_r : lr_raw;
    // Embedded timing decoder state for 8-bit 656 stream
    reg [1:0] sav_cnt_r;
    reg emb_v_r, emb_h_r, emb_f_r;
    wire emb = ctrl_r[`B_656];
    wire vs_l = emb ? emb_v_r : vs_raw;
    wire lr_l = emb ? ~emb_h_r : lr_use;
    wire vs_rise = vs_l & ~vs_d_r;
    wire vs_fall = ~vs_l & vs_d_r;
    wire field_edge = ctrl_r[`B_FD] ? vs_fall : vs_rise;
    wire line_start = lr_l & ~lr_d_r;
    // Capture counters and status
    reg [9:0] lskip_r, pskip_r;
    reg [10:0] line_r, pix_r;
    reg field_r, il_r, cb_r, half_r, vhalf_r;
    reg [7:0] lo_byte_r;
    reg [15:0] prev_r;
    reg [25:0] line_addr_r;
    reg act_r;
    wire [9:0] line_skip_count = crop_r[25:16];
    wire [9:0] pixel_skip_count = crop_r[9:0];
    wire [10:0] height = dim_r[26:16];
    wire [10:0] width = dim_r[10:0];
    wire w8 = ctrl_r[`B_W8] | emb;
    wire cur_flip = cb_r ? buf1_r[`B_FLIP] : buf0_r[`B_FLIP];
    wire cap_ok = ctrl_r[`B_EN] & (~ctrl_r[`B_CC] | cur_flip);
    wire fld_eff = field_r ^ ctrl_r[`B_FSW];
    // Weave or bob keeps both fields; an interlaced 656 stream with neither keeps one
    wire fld_take = ctrl_r[`B_WEAVE] | ctrl_r[`B_BOB] | ~il_r | ~fld_eff;
    // Line counter is bumped at each line start after the skipped lines, so captured lines are 1..height
    wire in_win = act_r & (lskip_r == 10'h000) & (pskip_r == 10'h000)
                  & (line_r != 11'h000) & (line_r <= height) & (pix_r < width);
    // Pixel word: byte pair, swaps, average
    reg [15:0] word;
    reg [15:0] pix;
    reg [7:0] yv;
    always @* begin
        word = w8 ? {din[7:0], lo_byte_r} : din;
        if (ctrl_r[`B_BSW]) begin
            word = {word[7:0], word[15:8]};
        end
        pix = word;
        if (ctrl_r[`B_UVS] & ~ctrl_r[`B_FMT]) begin
            pix = {prev_r[15:8], word[7:0]};
        end
        if (ctrl_r[`B_HA]) begin
            pix = {{1'b0, pix[15:9]} + {1'b0, prev_r[15:9]}, pix[7:0]};
        end
        yv = pix[7:0] + const_r[31:24];
        if (ctrl_r[`B_RGB] & ~ctrl_r[`B_FMT]) begin
            // Coarse conversion: luma plus offset constant, masked per channel by constants
            pix = {yv[7:3] & const_r[23:19], yv[7:2] & const_r[15:10],
                   yv[7:3] & const_r[7:3]};
        end
    end
    wire byte_ok = ~w8 | half_r;
    wire store = pix_en & lr_l & in_win & byte_ok & cap_ok & fld_take
                 & ~(ctrl_r[`B_HS] & pix_r[0]) & ~(ctrl_r[`B_VS] & vhalf_r);
    // FIFO of pixels toward memory
    reg [3:0] wp_r, rp_r;
    reg [4:0] cnt_r;
    wire [15:0] lb_q;
    reg push_d_r;
    // A word needs one cycle in memory before the registered read can show it
    wire pop = MEM_RD_REQ & ((cnt_r > 5'h01) | ((cnt_r == 5'h01) & ~push_d_r));
    // Read ahead so back-to-back pops each see the next word
    wire [3:0] rd_addr = pop ? rp_r + 4'h1 : rp_r;
    wire push = store & (cnt_r != `FIFO_DEPTH);
    vcp_linebuf u_lb (
        .clk(CLK_SYS),
        .we(push),
        .waddr(wp_r),
        .wdata(pix),
        .raddr(rd_addr),
        .rdata(lb_q)
    );
    reg [4:0] thr;
    always @* begin
        case (fifo_r)
            3'h0: thr = 5'h02;
            3'h1: thr = 5'h03;
            3'h2: thr = 5'h04;
            3'h3: thr = 5'h05;
            3'h4: thr = 5'h06;
            3'h5: thr = 5'h08;
            3'h6: thr = 5'h0A;
            default: thr = 5'h0C;
        endcase
    end
    assign FIFO_REQ = (`FIFO_DEPTH - cnt_r) >= thr;
    wire [25:0] base = cb_r ? {buf1_r[25:4], 4'h0} : {buf0_r[25:4], 4'h0};
    wire [1:0] mem_sel = cb_r ? buf1_r[27:26] : buf0_r[27:26];
    // Video timing, counters and buffer flipping
    always @(posedge CLK_SYS) begin
        if (!RSTN) begin
            ck_d_r <= 1'b0;
            vs_d_r <= 1'b0;
            lr_d_r <= 1'b0;
            lr_adj_r <= 1'b0;
            sav_cnt_r <= 2'h0;
            emb_v_r <= 1'b0;
            emb_h_r <= 1'b1;
            emb_f_r <= 1'b0;
            lskip_r <= 10'h000;
            pskip_r <= 10'h000;
            line_r <= 11'h000;
            pix_r <= 11'h000;
            field_r <= 1'b0;
            il_r <= 1'b0;
            cb_r <= 1'b0;
            half_r <= 1'b0;
            vhalf_r <= 1'b0;
            lo_byte_r <= 8'h00;
            prev_r <= 16'h0000;
            line_addr_r <= 26'h000_0000;
            act_r <= 1'b0;
            wp_r <= 4'h0;
            rp_r <= 4'h0;
            cnt_r <= 5'h00;
            push_d_r <= 1'b0;
            MEM_DATA <= 16'h0000;
            MEM_ADDR <= 26'h000_0000;
            MEM_EXT <= 1'b0;
            MEM_CS <= 1'b0;
            PANEL_VALID <= 1'b0;
            PANEL_DATA <= 16'h0000;
            PANEL_TRIG <= 1'b0;
        end else begin
            ck_d_r <= ck;
            vs_d_r <= vs_l;
            lr_d_r <= lr_l;
            PANEL_VALID <= 1'b0;
            PANEL_TRIG <= 1'b0;
            if (pix_en) begin
                lr_adj_r <= lr_raw;
                // Timing reference: FF 00 00 XY
                if (emb) begin
                    if (din[7:0] == `SAV_FF) begin
                        sav_cnt_r <= 2'h1;
                    end else if (sav_cnt_r == 2'h3) begin
                        emb_v_r <= din[`EAV_XY_V];
                        emb_h_r <= din[`EAV_XY_H];
                        emb_f_r <= din[`EAV_XY_F];
                        sav_cnt_r <= 2'h0;
                    end else if (sav_cnt_r != 2'h0) begin
                        sav_cnt_r <= (din[7:0] == 8'h00) ? sav_cnt_r + 2'h1 : 2'h0;
                    end
                end
                if (w8 & lr_l) begin
                    half_r <= ~half_r;
                    lo_byte_r <= din[7:0];
                end
                if (lr_l & byte_ok) begin
                    prev_r <= word;
                    if (pskip_r != 10'h000) begin
                        pskip_r <= pskip_r - 10'h001;
                    end else begin
                        pix_r <= pix_r + 11'h001;
                    end
                end
            end
            if (field_edge) begin
                field_r <= emb ? emb_f_r : ~field_r;
                il_r <= (field_r != (emb ? emb_f_r : ~field_r)) & (ctrl_r[`B_WEAVE]
                        | ctrl_r[`B_BOB] | emb);
                lskip_r <= line_skip_count;
                line_r <= 11'h000;
                vhalf_r <= 1'b0;
                act_r <= ctrl_r[`B_EN];
                line_addr_r <= base;
                // Flip when the frame is complete and double buffering on
                if (ctrl_r[`B_DB] & act_r & cap_ok) begin
                    cb_r <= ~cb_r;
                end
            end else if (line_start) begin
                pskip_r <= pixel_skip_count;
                pix_r <= 11'h000;
                half_r <= 1'b0;
                if (lskip_r != 10'h000) begin
                    lskip_r <= lskip_r - 10'h001;
                end else if (line_r <= height) begin
                    line_r <= line_r + 11'h001;
                    vhalf_r <= ~vhalf_r;
                    if (~(ctrl_r[`B_VS] & vhalf_r)) begin
                        line_addr_r <= line_addr_r + {10'h000, pitch_r[15:4], 4'h0};
                    end
                    if (line_r == lcmp_r[10:0]) begin
                        PANEL_TRIG <= 1'b1;
                    end
                end
            end
            if (push) begin
                wp_r <= wp_r + 4'h1;
                MEM_ADDR <= line_addr_r + {15'h0000, pix_r};
                MEM_EXT <= mem_sel[1];
                MEM_CS <= mem_sel[0];
                PANEL_VALID <= ctrl_r[`B_PNL];
                PANEL_DATA <= pix;
            end
            if (pop) begin
                rp_r <= rp_r + 4'h1;
                MEM_DATA <= lb_q;
            end
            cnt_r <= cnt_r + {4'h0, push} - {4'h0, pop};
            push_d_r <= push;
        end
    end
    // Register writes; flip bit cleared by hardware on switch, software set wins
    wire flip_ev = field_edge & ctrl_r[`B_DB] & act_r & cap_ok;
    always @(posedge CLK_SYS) begin
        if (!RSTN) begin
            ctrl_r <= 32'h0000_0000;
            crop_r <= 32'h0000_0000;
            dim_r <= 32'h0000_0000;
            buf0_r <= 32'h0000_0000;
            buf1_r <= 32'h0000_0000;
            pitch_r <= 32'h0000_0000;
            fifo_r <= `VCP_RST_FIFO;
            const_r <= `VCP_RST_CONST;
            lcmp_r <= 32'h0000_0000;
        end else begin
            if (flip_ev & ~cb_r) begin
                buf0_r[`B_FLIP] <= 1'b0;
            end
            if (flip_ev & cb_r) begin
                buf1_r[`B_FLIP] <= 1'b0;
            end
            if (WR) begin
                case (ADDR)
                    `VCP_A_CTRL: ctrl_r <= WDATA & `VCP_CTRL_WMASK;
                    `VCP_A_CROP: crop_r <= WDATA & `VCP_CROP_WMASK;
                    `VCP_A_DIM: dim_r <= WDATA & `VCP_DIM_WMASK;
                    `VCP_A_BUF0: buf0_r <= WDATA & `VCP_BUF_WMASK;
                    `VCP_A_BUF1: buf1_r <= WDATA & `VCP_BUF_WMASK;
                    `VCP_A_PITCH: pitch_r <= WDATA & `VCP_PITCH_WMASK;
                    `VCP_A_FIFO: fifo_r <= WDATA[2:0];
                    `VCP_A_CONST: const_r <= WDATA;
                    `VCP_A_LCMP: lcmp_r <= WDATA & `VCP_LCMP_WMASK;
                    default: ;
                endcase
            end
        end
    end
    // Read data one cycle after strobe; unmapped reads zero
    always @(posedge CLK_SYS) begin
        if (!RSTN) begin
            RDATA <= 32'h0000_0000;
        end else if (RD) begin
            case (ADDR)
                `VCP_A_CTRL: RDATA <= ctrl_r | ({31'h0, field_r} << `B_FLD)
                    | ({31'h0, il_r} << `B_IL) | ({31'h0, cb_r} << `B_CB)
                    | ({31'h0, vs_l} << `B_VSS);
                `VCP_A_CROP: RDATA <= crop_r;
                `VCP_A_DIM: RDATA <= dim_r;
                `VCP_A_BUF0: RDATA <= buf0_r;
                `VCP_A_BUF1: RDATA <= buf1_r;
                `VCP_A_PITCH: RDATA <= pitch_r;
                `VCP_A_FIFO: RDATA <= {29'h0, fifo_r};
                `VCP_A_CONST: RDATA <= const_r;
                `VCP_A_LCMP: RDATA <= lcmp_r;
                default: RDATA <= 32'h0000_0000;
            endcase
        end else begin
            RDATA <= 32'h0000_0000;
        end
    end
endmodule

// ==== verification/vcp_video_src.sv ====
`timescale 1ns/1ps
// Behavioural video decoder; link clock stands still between frames
module vcp_video_src (
    // Video pins
    output logic pclk,
    output logic vsync,
    output logic line_ref,
    output logic [15:0] vdata
);
    logic [15:0] px[4][8];
    initial begin
        pclk = 0;
        vsync = 0;
        line_ref = 0;
        vdata = 16'h0000;
    end
    // One link clock; data moves on the falling edge, idle data toggles so it is never stale
    task automatic tick();
        #400 pclk = 1;
        #400 pclk = 0;
        if (!line_ref) vdata = ~vdata;
    endtask
    // Frame of nl lines of 8 pixels, syncs active high
    task automatic frame(input int nl);
        vsync = 1;
        tick();
        tick();
        vsync = 0;
        tick();
        for (int l = 0; l < nl; l++) begin
            line_ref = 1;
            for (int p = 0; p < 8; p++) begin
                px[l][p] = $urandom;
                vdata = px[l][p];
                tick();
            end
            line_ref = 0;
            tick();
            tick();
        end
    endtask
endmodule

// ==== verification/vcp_capture_properties.sv ====
`timescale 1ns/1ps
`include "vcp_map.vh"
module vcp_capture_properties (
    // System
    input logic CLK_SYS,
    input logic RSTN,
    // Register port
    input logic [23:0] ADDR,
    input logic [31:0] WDATA,
    input logic WR,
    input logic RD,
    input logic [31:0] RDATA,
    // Outputs watched
    input logic FIFO_REQ,
    input logic PANEL_VALID
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);
    // Bits outside the mask read as zero after a read of address a
    property masked(a, m);
        $past(RD) && $past(ADDR) == a |-> (RDATA & ~m) == 32'h0000_0000;
    endproperty
    // A write then a read of a returns the written bits under m
    property back(a, m);
        WR && ADDR == a ##2 RD && ADDR == a |=> (RDATA & m) == ($past(WDATA, 3) & m);
    endproperty
    AST_CTRL_RSVD: assert property (masked(`VCP_A_CTRL, 32'h0F1F_FFFF))
        else $error("control reserved bits set");
    AST_CROP_RSVD: assert property (masked(`VCP_A_CROP, `VCP_CROP_WMASK))
        else $error("skip register reserved bits set");
    AST_DIM_RSVD: assert property (masked(`VCP_A_DIM, `VCP_DIM_WMASK))
        else $error("size register reserved bits set");
    AST_BUF0_LOW: assert property (masked(`VCP_A_BUF0, `VCP_BUF_WMASK))
        else $error("buffer 0 low bits set");
    AST_BUF1_LOW: assert property (masked(`VCP_A_BUF1, `VCP_BUF_WMASK))
        else $error("buffer 1 low bits set");
    AST_PITCH_LOW: assert property (masked(`VCP_A_PITCH, `VCP_PITCH_WMASK))
        else $error("pitch low bits set");
    AST_LCMP_RSVD: assert property (masked(`VCP_A_LCMP, `VCP_LCMP_WMASK))
        else $error("line compare reserved bits set");
    AST_FIFO_BACK: assert property (back(`VCP_A_FIFO, 32'h0000_0007))
        else $error("threshold readback wrong");
    AST_CONST_BACK: assert property (back(`VCP_A_CONST, 32'hFFFF_FFFF))
        else $error("constants readback wrong");
    AST_CTRL_BACK: assert property (back(`VCP_A_CTRL, 32'h001F_FFFF))
        else $error("control readback wrong");
    // Main scenarios reached
    cover property (PANEL_VALID);
    cover property (!FIFO_REQ);
    cover property ($past(WR) && RD);
endmodule
bind vcp_capture vcp_capture_properties i_props (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .FIFO_REQ(FIFO_REQ), .PANEL_VALID(PANEL_VALID));

// ==== verification/test_video_capture_port.sv ====
`timescale 1ns/1ps
`include "vcp_map.vh"
module test_video_capture_port;
    logic CLK_SYS = 0, RSTN = 0, WR = 0, RD = 0, MEM_RD_REQ = 0, bs;
    logic [23:0] ADDR = 24'h00_0000;
    logic [31:0] WDATA = 32'h0000_0000, rv, w, bw;
    wire PCLK, VSYNC, LINE_REF, FIFO_REQ, MEM_EXT, MEM_CS, PANEL_VALID, PANEL_TRIG;
    wire [15:0] VDATA, MEM_DATA, PANEL_DATA;
    wire [25:0] MEM_ADDR;
    logic [15:0] got[$];
    int bad_count = 0, compares = 0, cyc = 0, i, trig_n = 0, t0;
    wire [31:0] RDATA_w;
    logic [23:0] ra[9] = '{`VCP_A_CTRL, `VCP_A_CROP, `VCP_A_DIM, `VCP_A_BUF0,
        `VCP_A_BUF1, `VCP_A_PITCH, `VCP_A_FIFO, `VCP_A_CONST, `VCP_A_LCMP};
    logic [31:0] rm[9] = '{`VCP_CTRL_WMASK, `VCP_CROP_WMASK, `VCP_DIM_WMASK,
        `VCP_BUF_WMASK, `VCP_BUF_WMASK, `VCP_PITCH_WMASK, 32'h0000_0007,
        32'hFFFF_FFFF, `VCP_LCMP_WMASK};
    always #50 CLK_SYS = ~CLK_SYS;
    vcp_capture i_dut (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA_w), .PCLK(PCLK), .VSYNC(VSYNC),
        .LINE_REF(LINE_REF), .VDATA(VDATA), .MEM_RD_REQ(MEM_RD_REQ),
        .FIFO_REQ(FIFO_REQ), .MEM_DATA(MEM_DATA), .MEM_ADDR(MEM_ADDR),
        .MEM_EXT(MEM_EXT), .MEM_CS(MEM_CS), .PANEL_VALID(PANEL_VALID),
        .PANEL_DATA(PANEL_DATA), .PANEL_TRIG(PANEL_TRIG));
    vcp_video_src i_src (.pclk(PCLK), .vsync(VSYNC), .line_ref(LINE_REF), .vdata(VDATA));
    // Collect panel pixels; cut a hang short
    always @(posedge CLK_SYS) begin
        if (PANEL_VALID === 1'b1) got.push_back(PANEL_DATA);
        if (PANEL_TRIG === 1'b1) trig_n <= trig_n + 1;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            test_done();
        end
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Bus cycles; each leaves one idle edge so a strobe is never set twice in a step
    task automatic wr(input logic [23:0] a, input logic [31:0] d);
        WR <= 1;
        ADDR <= a;
        WDATA <= d;
        @(posedge CLK_SYS);
        WR <= 0;
        @(posedge CLK_SYS);
    endtask
    task automatic rd(input logic [23:0] a, output logic [31:0] d);
        RD <= 1;
        ADDR <= a;
        @(posedge CLK_SYS);
        RD <= 0;
        #1 d = RDATA_w;
        @(posedge CLK_SYS);
    endtask
    // Empty entries needed for a request, per threshold code
    function automatic int thr(input int c);
        return c < 5 ? c + 2 : 2 * c - 2;
    endfunction
    task automatic test_done();
        if (bad_count == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        void'($urandom(61007));
        repeat (12) @(posedge CLK_SYS);
        RSTN <= 1;
        @(posedge CLK_SYS);
        // Defaults and an unmapped place
        rd(`VCP_A_FIFO, rv); check("fifo_rst", rv, 32'h0000_0004);
        rd(`VCP_A_CONST, rv); check("const_rst", rv, `VCP_RST_CONST);
        rd(`VCP_A_LCMP, rv); check("lcmp_rst", rv, 32'h0000_0000);
        rd(`VCP_A_CTRL, rv); check("ctrl_rst", rv, 32'h0000_0000);
        wr(24'h09_8020, 32'hFFFF_FFFF);
        rd(24'h09_8020, rv); check("unmapped", rv, 32'h0000_0000);
        // Random values through every register; status bits left out of control
        for (i = 0; i < 9; i++) begin
            w = $urandom;
            wr(ra[i], w);
            rd(ra[i], rv);
            check("readback", rv & (i == 0 ? 32'hF0FF_FFFF : 32'hFFFF_FFFF), w & rm[i]);
        end
        // Skip one line and pixel, keep 6 by 2, panel on, random byte order
        bs = $urandom;
        bw = ($urandom & 32'h0C00_0000) | 32'h0000_1000;
        wr(`VCP_A_CROP, 32'h0001_0001);
        wr(`VCP_A_DIM, 32'h0002_0006);
        wr(`VCP_A_BUF0, bw);
        wr(`VCP_A_FIFO, 32'h0000_0004);
        wr(`VCP_A_PITCH, 32'h0000_0040);
        wr(`VCP_A_LCMP, 32'h0000_0001);
        wr(`VCP_A_CTRL, 32'h0010_0001 | (32'(bs) << `B_BSW));
        got.delete();
        t0 = trig_n;
        i_src.frame(3);
        repeat (10) @(posedge CLK_SYS);
        check("count", got.size(), 12);
        for (i = 0; i < 12; i++) begin
            w = i_src.px[1 + i / 6][1 + i % 6];
            check("pixel", got[i], bs ? {w[7:0], w[15:8]} : w[15:0]);
        end
        check("mem_sel", {MEM_EXT, MEM_CS}, bw[27:26]);
        check("mem_addr", MEM_ADDR, 32'h0000_1085);
        check("trig", trig_n - t0, 1);
        rd(`VCP_A_CTRL, rv); check("status", rv[25:24], 2'b00);
        // Twelve entries held, four empty: every threshold code
        for (i = 0; i < 8; i++) begin
            wr(`VCP_A_FIFO, i);
            check("fifo_req", FIFO_REQ, 4 >= thr(i));
        end
        MEM_RD_REQ <= 1;
        repeat (20) @(posedge CLK_SYS);
        MEM_RD_REQ <= 0;
        @(posedge CLK_SYS);
        check("drained", FIFO_REQ, 1);
        w = i_src.px[2][6];
        check("mem_data", MEM_DATA, bs ? {w[7:0], w[15:8]} : w[15:0]);
        // Capture off: nothing reaches the panel
        wr(`VCP_A_CTRL, 32'h0010_0000);
        got.delete();
        i_src.frame(3);
        repeat (10) @(posedge CLK_SYS);
        check("off", got.size(), 0);
        test_done();
    end
endmodule
